// File: logic/wiper_host_params.svh
`ifndef WIPER_HOST_PARAMS_SVH
`define WIPER_HOST_PARAMS_SVH
`define CLK_PERIOD_NS      10
`define POWERUP_WAIT_US    1000
`define POWERUP_WAIT_CYC   ((`POWERUP_WAIT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HALF_STEP_NS       1000
`define HALF_STEP_CYC      ((`HALF_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POS_WIDTH          5
`define TAP_COUNT          32
`define POS_MAX            5'h1F
`define POS_MIN            5'h00
`endif

// File: logic/wiper_host_pkg.sv
package wiper_host_pkg;
   typedef enum logic [2:0] {
      st_power_wait,
      st_idle,
      st_select,
      st_strobe_low,
      st_strobe_high,
      st_release,
      st_done
   } host_state_e;
endpackage

// File: logic/step_tick.sv
`timescale 1ns/10ps
`default_nettype none
module step_tick #(
   parameter int DIVIDE = 100
) (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic reset_n,
   // enable pulse
   output logic      tick
);
   if (DIVIDE < 1) begin : g_bad_divide
      $error("divide must be at least one");
   end

   logic [31:0] count;
   wire         wrap = (count >= 32'(DIVIDE - 1));

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         count <= 32'h0;
         tick  <= 1'b0;
      end else begin
         count <= wrap ? 32'h0 : count + 32'h1;
         tick  <= wrap;
      end
   end
endmodule
`default_nettype wire

// File: logic/wiper_host.sv
// Operation
// - deselect with strobe high saves position
// - deselect with strobe low skips save
// - direction may change while selected (this host sets it at command take and holds it until deselect)
// - wait 1 ms after power before stepping
`timescale 1ns/10ps
`default_nettype none
`include "wiper_host_params.svh"
module wiper_host
   import wiper_host_pkg::*;
#(
   parameter int POWERUP_CYC = `POWERUP_WAIT_CYC,
   parameter int HALF_CYC    = `HALF_STEP_CYC
) (
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  reset_n,
   // command
   input  wire logic                  cmd_valid,
   input  wire logic                  cmd_up,
   input  wire logic [`POS_WIDTH-1:0] cmd_steps,
   input  wire logic                  cmd_save,
   output logic                       cmd_ready,
   output logic                       cmd_done,
   // tracked position
   output logic [`POS_WIDTH-1:0]      position,
   output logic                       position_known,
   // device pins
   output logic                       chip_select_n,
   output logic                       step_strobe_n,
   output logic                       direction_sel
);
   // refuse counts the divider and wait counter cannot serve
   if (POWERUP_CYC < 1 || HALF_CYC < 1) begin : g_bad_timing
      $error("timing counts must be at least one");
   end
   // position width must cover every tap
   if ((1 << `POS_WIDTH) != `TAP_COUNT) begin : g_bad_taps
      $error("position width does not cover the taps");
   end

   host_state_e           state;
   host_state_e           next_state;
   logic [31:0]           wait_count;
   logic [`POS_WIDTH-1:0] steps_left;
   logic                  save_req;
   logic                  up_req;
   logic                  tick;

   step_tick #(.DIVIDE(HALF_CYC)) u_tick (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .tick     (tick)
   );

   // one decode shared by the tick-qualified state wires below; the sequencer tests tick itself
   function automatic logic at_tick(input host_state_e now,
                                    input host_state_e want,
                                    input logic        pulse);
      return pulse && (now == want);
   endfunction

   wire powered   = (wait_count >= 32'(POWERUP_CYC));
   wire last_step = (steps_left == 5'h01);
   wire no_steps  = (steps_left == 5'h00);
   wire at_top    = (position == `POS_MAX);
   wire at_bottom = (position == `POS_MIN);
   // model the device's saturating counter
   wire [`POS_WIDTH-1:0] next_position =
      (up_req && !at_top)     ? position + 5'h01 :
      (!up_req && !at_bottom) ? position - 5'h01 :
      position;

   // state decodes
   wire take         = (state == st_idle) && cmd_valid;
   wire select_tick  = at_tick(state, st_select, tick);
   wire low_tick     = at_tick(state, st_strobe_low, tick);
   wire high_tick    = at_tick(state, st_strobe_high, tick);
   wire release_tick = at_tick(state, st_release, tick);
   wire done_now     = (state == st_done);

   // pin decodes: without save the strobe stays low after the last fall
   wire keep_low     = last_step && !save_req;
   wire strobe_fall  = (select_tick && (!no_steps || !save_req))
                    || (high_tick && !last_step);
   wire strobe_rise  = (low_tick && !keep_low) || done_now;
   wire pos_move     = (select_tick && !no_steps) || (high_tick && !last_step);

   // command sequencer
   always_comb begin
      next_state = state;
      case (state)
         st_power_wait: begin
            if (powered) begin
               next_state = st_idle;
            end
         end
         st_idle: begin
            if (cmd_valid) begin
               next_state = st_select;
            end
         end
         st_select: begin
            if (tick) begin
               next_state = (steps_left == 5'h00) ? st_release : st_strobe_low;
            end
         end
         st_strobe_low: begin
            if (tick) begin
               next_state = keep_low ? st_release : st_strobe_high;
            end
         end
         st_strobe_high: begin
            if (tick) begin
               next_state = last_step ? st_release : st_strobe_low;
            end
         end
         st_release: begin
            if (tick) begin
               next_state = st_done;
            end
         end
         st_done: begin
            next_state = st_idle;
         end
         default: begin
            next_state = st_idle;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state <= st_power_wait;
      end else begin
         state <= next_state;
      end
   end

   // supply settle count
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         wait_count <= 32'h0;
      end else if (!powered) begin
         wait_count <= wait_count + 32'h1;
      end
   end

   // command latch, step countdown
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         steps_left <= 5'h00;
         save_req   <= 1'b0;
         up_req     <= 1'b0;
      end else if (take) begin
         steps_left <= cmd_steps;
         save_req   <= cmd_save;
         up_req     <= cmd_up;
      end else if (high_tick) begin
         steps_left <= steps_left - 5'h01;
      end
   end

   // pins: select low frames every strobe fall
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         chip_select_n <= 1'b1;
         step_strobe_n <= 1'b1;
         direction_sel <= 1'b0;
      end else begin
         if (take) begin
            chip_select_n <= 1'b0;
            direction_sel <= cmd_up;
         end else if (release_tick) begin
            chip_select_n <= 1'b1;
         end
         if (strobe_fall) begin
            step_strobe_n <= 1'b0;
         end else if (strobe_rise) begin
            step_strobe_n <= 1'b1;
         end
      end
   end

   // position tracking, unknown until first save after power-up
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         position       <= `POS_MIN;
         position_known <= 1'b0;
      end else begin
         if (pos_move) begin
            position <= next_position;
         end
         if (done_now && save_req) begin
            position_known <= 1'b1;
         end
      end
   end

   // handshake flags
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cmd_ready <= 1'b0;
         cmd_done  <= 1'b0;
      end else begin
         cmd_ready <= (next_state == st_idle) && !(state == st_idle && cmd_valid);
         cmd_done  <= (state == st_done);
      end
   end
endmodule
`default_nettype wire

// File: verification/wiper_host_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "wiper_host_params.svh"
module wiper_host_checker (
   // clock and reset
   input wire logic                  core_clk,
   input wire logic                  reset_n,
   // command handshake
   input wire logic                  cmd_valid,
   input wire logic                  cmd_ready,
   input wire logic                  cmd_done,
   // tracked position
   input wire logic [`POS_WIDTH-1:0] position,
   // device pins
   input wire logic                  chip_select_n,
   input wire logic                  step_strobe_n,
   input wire logic                  direction_sel
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   a_strobe_in_select: assert property ($fell(step_strobe_n) |-> !chip_select_n)
      else $error("strobe fell while deselected");
   a_select_by_take: assert property (
      $fell(chip_select_n) |-> $past(cmd_valid) && $past(cmd_ready))
      else $error("select without command");
   a_take_selects: assert property (
      cmd_valid && cmd_ready |=> !chip_select_n && !cmd_ready)
      else $error("command not started");
   a_ready_idle: assert property (cmd_ready |-> chip_select_n && step_strobe_n)
      else $error("ready while pins busy");
   a_pos_by_one: assert property ($changed(position) |->
      position - $past(position) == 5'h01 || $past(position) - position == 5'h01)
      else $error("position jumped");
   a_pos_direction: assert property ($changed(position) |->
      (direction_sel ? position > $past(position) : position < $past(position)))
      else $error("position wrong way or wrapped");
   a_dir_steady: assert property (
      !chip_select_n && !$past(chip_select_n) |-> $stable(direction_sel))
      else $error("direction moved mid command");
   a_done_after_deselect: assert property ($rose(chip_select_n) |-> ##[1:4] cmd_done)
      else $error("no done after deselect");
   a_done_pulse: assert property (cmd_done |-> chip_select_n ##1 !cmd_done)
      else $error("done not a single pulse");
endmodule
`default_nettype wire

// File: verification/wiper_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module wiper_dev_model #(
   parameter logic [4:0] INIT_SAVED = 5'h00
) (
   // power and pins
   input  wire logic        power_on,
   input  wire logic        chip_select_n,
   input  wire logic        step_strobe_n,
   input  wire logic        direction_sel,
   // state seen
   output logic [4:0]       count,
   output logic [4:0]       saved,
   output logic             standby,
   output logic [31:0]      tap
);
   initial saved = INIT_SAVED;
   initial standby = 1'b0;
   always @(posedge power_on) count = saved;
   always @(negedge step_strobe_n) if (power_on && !chip_select_n) begin
      if (direction_sel && count != 5'h1F) count = count + 5'h01;
      else if (!direction_sel && count != 5'h00) count = count - 5'h01;
   end
   always @(posedge chip_select_n) if (power_on && step_strobe_n) begin
      saved = count;
      standby = 1'b1;
   end
   always @(negedge chip_select_n) standby = 1'b0;
   assign tap = 32'h1 << count;
endmodule
`default_nettype wire

// File: verification/test_wiper_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "wiper_host_params.svh"
module test_wiper_host;
   typedef struct packed {logic up; logic [4:0] steps; logic save; logic [4:0] pos, kept;} row_s;
   row_s rows [7] = '{'{1'h1,5'h05,1'h1,5'h05,5'h05}, '{1'h0,5'h02,1'h0,5'h03,5'h05},
      '{1'h1,5'h1F,1'h1,5'h1F,5'h1F}, '{1'h0,5'h00,1'h1,5'h1F,5'h1F},
      '{1'h0,5'h1F,1'h0,5'h00,5'h1F}, '{1'h0,5'h03,1'h1,5'h00,5'h00},
      '{1'h1,5'h01,1'h1,5'h01,5'h01}};
   logic        core_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        cmd_valid = 1'b0;
   logic        cmd_up = 1'b0;
   logic        cmd_save = 1'b0;
   logic [4:0]  cmd_steps = 5'h00;
   logic        cmd_ready, cmd_done, position_known, chip_select_n, step_strobe_n, direction_sel;
   logic [4:0]  position, dev_count, dev_saved;
   logic [31:0] dev_tap;
   logic        dev_standby;
   int          checks = 0;
   int          failures = 0;
   int          n;
   wiper_host #(.POWERUP_CYC(10), .HALF_CYC(2)) u_wiper_host (.core_clk(core_clk),
      .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_up(cmd_up), .cmd_steps(cmd_steps),
      .cmd_save(cmd_save), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .position(position),
      .position_known(position_known), .chip_select_n(chip_select_n),
      .step_strobe_n(step_strobe_n), .direction_sel(direction_sel));
   wiper_dev_model u_wiper_dev_model (.power_on(reset_n), .chip_select_n(chip_select_n),
      .step_strobe_n(step_strobe_n), .direction_sel(direction_sel), .count(dev_count),
      .saved(dev_saved), .standby(dev_standby), .tap(dev_tap));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wait_ready();
      n = 0;
      while (cmd_ready !== 1'b1 && n < 500) begin
         @(negedge core_clk);
         n++;
      end
      if (cmd_ready !== 1'b1) failures++;
   endtask
   task automatic run(input logic up, input logic [4:0] steps, input logic save);
      wait_ready();
      cmd_up = up;
      cmd_steps = steps;
      cmd_save = save;
      cmd_valid = 1'b1;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      for (int k = 0; k < 500 && cmd_done !== 1'b1; k++) @(negedge core_clk);
      if (cmd_done !== 1'b1) failures++;
   endtask
   initial forever #5 core_clk = ~core_clk;
   initial begin
      #50000;
      failures++;
      finish_test();
   end
   initial begin
      repeat (5) @(negedge core_clk);
      reset_n = 1'b1;
      foreach (rows[i]) begin
         run(rows[i].up, rows[i].steps, rows[i].save);
         check(position, rows[i].pos);
         check(dev_count, rows[i].pos);
         check(dev_saved, rows[i].kept);
         check(dev_tap, 32'h1 << rows[i].pos);
         check(dev_standby, rows[i].save);
      end
      check(position_known, 1'b1);
      reset_n = 1'b0;
      repeat (5) @(negedge core_clk);
      check({chip_select_n, step_strobe_n, direction_sel, cmd_ready}, 4'hC);
      check({position_known, position}, 6'h00);
      reset_n = 1'b1;
      wait_ready();
      check(n >= 10, 1'b1);
      check(dev_count, 5'h01);
      run(1'b1, 5'h02, 1'b0);
      check(dev_count, 5'h03);
      check(dev_saved, 5'h01);
      finish_test();
   end
endmodule
bind wiper_host wiper_host_checker u_wiper_host_checker (.core_clk(core_clk),
   .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
   .position(position), .chip_select_n(chip_select_n), .step_strobe_n(step_strobe_n),
   .direction_sel(direction_sel));
`default_nettype wire
